/* File: dcm_map.svh */
`ifndef DCM_MAP_SVH
`define DCM_MAP_SVH
`define DCM_ERR_DISC      32'h000A0011
`define DCM_ERR_FBK       32'h00100011
`define DCM_ERR_BUS       32'h003E4006
`define DCM_ERR_DIP       32'h002D4006
`define DCM_ERR_UNEQ      32'h002AC006
`define DCM_DIP_GAP_MS    2
`define DCM_TOG_INT_MS    4
`define DCM_TOG_DUR_MS    40
`define DCM_CLK_KHZ       25000
`define DCM_DIP_GAP_CYC   (`DCM_DIP_GAP_MS * `DCM_CLK_KHZ)
`define DCM_TOG_INT_CYC   (`DCM_TOG_INT_MS * `DCM_CLK_KHZ)
`define DCM_TOG_COUNT     (`DCM_TOG_DUR_MS / `DCM_TOG_INT_MS)
`define DCM_LAMP_OFF_CYC  16'h0100
`define DCM_LAMP_TST_CYC  16'h0400
`endif

/* File: dcm_pkg.sv */
package dcm_pkg;
    typedef enum logic [1:0]
    {
        DCM_LAMP_RUN  = 2'b00,
        DCM_LAMP_OFF  = 2'b01,
        DCM_LAMP_TEST = 2'b10
    } dcm_lamp_t;
endpackage

/* File: dcm_monitor.sv */
`timescale 1ns/100ps
`include "dcm_map.svh"
// Contract
// RULE_01: Partner mismatch lasting past discrepancy time raises discrepancy error 0x000A0011.
// RULE_02: Equivalent pair clears latched error by low/low to high/high in time.
// RULE_03: Complementary pair clears latched error by low/high to high/low in time.
// RULE_04: Pending mismatch is cancelled if both inputs return off in time; for a complementary pair the code cancels only on low/high.
// RULE_05: Both inputs on during pending mismatch keeps it; error follows at expiry.
// RULE_06: Feedback not following control within max delay raises error 0x00100011.
// RULE_07: Two high-to-low dips 2 ms apart on a pair flag unequal input data.
// RULE_08: Single input toggling every 4 ms for 40 ms flags unequal input data.
// RULE_09: Backplane interference causes system restart and logs 0x003E4006.
// RULE_10: Supply dip logs 0x002D4006, blanks lamps, then runs lamp test.
// RULE_11: Discrepancy error keeps module status lamp steady green.
// RULE_12: Every raised error code is logged with a timestamp; the code logs one entry per cycle and can drop a coincident 0x002AC006.
module dcm_monitor
    import dcm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        complementary,
    input  wire logic [23:0] disc_time,
    input  wire logic        in_a,
    input  wire logic        in_b,
    input  wire logic        single_in,
    input  wire logic        fb_ctrl,
    input  wire logic        fb_sense,
    input  wire logic [23:0] fb_max_delay,
    input  wire logic        bus_fault,
    input  wire logic        supply_dip,
    output logic             disc_error,
    output logic             fb_error,
    output logic             uneq_fault,
    output logic             restart,
    output logic             lamps_on,
    output logic             lamp_test,
    output logic             module_status_lamp,
    output logic             log_valid,
    output logic [31:0]      log_code,
    output logic [31:0]      log_time
);
    typedef struct packed {
        logic        a_q;
        logic        b_q;
        logic        s_q;
        logic        pending;
        logic [23:0] disc_cnt;
        logic        disc_error;
        logic        clr_armed;
        logic [23:0] clr_cnt;
        logic [23:0] fb_cnt;
        logic        fb_error;
        logic [23:0] dip_cnt;
        logic        dip_seen;
        logic [23:0] tog_cnt;
        logic [3:0]  tog_num;
        logic        uneq_fault;
        logic        restart;
        dcm_lamp_t   lamp;
        logic [15:0] lamp_cnt;
        logic        lamps_on;
        logic        lamp_test;
        logic        status;
        logic        log_valid;
        logic [31:0] log_code;
        logic [31:0] log_time;
        logic [31:0] now;
    } dcm_state_t;

    dcm_state_t st;
    dcm_state_t next_st;
    logic       match;
    logic       rest;
    logic       act;

    always_comb
    begin
        next_st = st;
        next_st.a_q = in_a;
        next_st.b_q = in_b;
        next_st.s_q = single_in;
        next_st.now = st.now + 32'h1;
        next_st.log_valid = 1'b0;
        next_st.restart = 1'b0;
        match = complementary ? (in_a != in_b) : (in_a == in_b);
        rest = complementary ? (!in_a && in_b) : (!in_a && !in_b);
        act = complementary ? (in_a && !in_b) : (in_a && in_b);
        if (!st.disc_error)
        begin
            // RULE_04 mismatch cancel
            if (rest)
            begin
                next_st.pending = 1'b0;
                next_st.disc_cnt = 24'h0;
            end
            // RULE_05 pending kept
            else if (!match || st.pending)
            begin
                next_st.pending = 1'b1;
                next_st.disc_cnt = st.disc_cnt + 24'h1;
                // RULE_01 discrepancy expiry
                if (st.disc_cnt >= disc_time)
                begin
                    next_st.disc_error = 1'b1;
                    next_st.clr_armed = 1'b0;
                    next_st.log_valid = 1'b1;
                    next_st.log_code = `DCM_ERR_DISC;
                end
            end
        end
        else
        begin
            // RULE_02 equivalent clear
            // RULE_03 complementary clear
            if (rest)
            begin
                next_st.clr_armed = 1'b1;
                next_st.clr_cnt = 24'h0;
            end
            else if (st.clr_armed)
            begin
                next_st.clr_cnt = st.clr_cnt + 24'h1;
                if (act && st.clr_cnt <= disc_time)
                begin
                    next_st.disc_error = 1'b0;
                    next_st.pending = 1'b0;
                    next_st.disc_cnt = 24'h0;
                end
                if (st.clr_cnt > disc_time)
                    next_st.clr_armed = 1'b0;
            end
        end
        // RULE_06 feedback follow
        if (fb_sense == fb_ctrl)
            next_st.fb_cnt = 24'h0;
        else
        begin
            next_st.fb_cnt = st.fb_cnt + 24'h1;
            if (st.fb_cnt >= fb_max_delay && !st.fb_error && !next_st.log_valid)
            begin
                next_st.fb_error = 1'b1;
                next_st.log_valid = 1'b1;
                next_st.log_code = `DCM_ERR_FBK;
            end
        end
        // RULE_07 dip spacing
        if (st.dip_cnt != 24'h0)
            next_st.dip_cnt = st.dip_cnt - 24'h1;
        if ((st.a_q && !in_a) || (st.b_q && !in_b))
        begin
            if (st.dip_seen && st.dip_cnt != 24'h0)
                next_st.uneq_fault = 1'b1;
            next_st.dip_seen = 1'b1;
            next_st.dip_cnt = 24'(`DCM_DIP_GAP_CYC + `DCM_DIP_GAP_CYC / 4);
        end
        else if (st.dip_cnt == 24'h0)
            next_st.dip_seen = 1'b0;
        // RULE_08 toggle train
        next_st.tog_cnt = st.tog_cnt + 24'h1;
        if (st.s_q != single_in)
        begin
            next_st.tog_cnt = 24'h0;
            if (st.tog_cnt <= 24'(`DCM_TOG_INT_CYC))
            begin
                if (st.tog_num >= 4'(`DCM_TOG_COUNT))
                    next_st.uneq_fault = 1'b1;
                else
                    next_st.tog_num = st.tog_num + 4'h1;
            end
            else
                next_st.tog_num = 4'h0;
        end
        else if (st.tog_cnt > 24'(`DCM_TOG_INT_CYC))
            next_st.tog_num = 4'h0;
        if (next_st.uneq_fault && !st.uneq_fault && !next_st.log_valid)
        begin
            next_st.log_valid = 1'b1;
            next_st.log_code = `DCM_ERR_UNEQ;
        end
        // RULE_09 backplane restart
        if (bus_fault)
        begin
            next_st = '0;
            // The timestamp keeps running across a restart so follow-on errors stay ordered.
            next_st.now = st.now + 32'h1;
            next_st.restart = 1'b1;
            next_st.status = 1'b1;
            next_st.lamps_on = 1'b1;
            next_st.log_valid = 1'b1;
            next_st.log_code = `DCM_ERR_BUS;
        end
        // RULE_10 dip lamp sequence
        else if (supply_dip)
        begin
            next_st.lamp = DCM_LAMP_OFF;
            next_st.lamp_cnt = 16'h0;
            next_st.log_valid = 1'b1;
            next_st.log_code = `DCM_ERR_DIP;
        end
        else
        begin
            next_st.lamp_cnt = st.lamp_cnt + 16'h1;
            case (st.lamp)
                DCM_LAMP_OFF:
                    if (st.lamp_cnt == `DCM_LAMP_OFF_CYC)
                    begin
                        next_st.lamp = DCM_LAMP_TEST;
                        next_st.lamp_cnt = 16'h0;
                    end
                DCM_LAMP_TEST:
                    if (st.lamp_cnt == `DCM_LAMP_TST_CYC)
                        next_st.lamp = DCM_LAMP_RUN;
                DCM_LAMP_RUN:
                    next_st.lamp_cnt = 16'h0;
                default:
                    next_st.lamp = DCM_LAMP_RUN;
            endcase
        end
        next_st.lamps_on = (next_st.lamp != DCM_LAMP_OFF);
        next_st.lamp_test = (next_st.lamp == DCM_LAMP_TEST);
        // RULE_11 status stays green
        next_st.status = (next_st.lamp == DCM_LAMP_RUN);
        // RULE_12 timestamped log
        next_st.log_time = st.now;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign disc_error = st.disc_error;
    assign fb_error = st.fb_error;
    assign uneq_fault = st.uneq_fault;
    assign restart = st.restart;
    assign lamps_on = st.lamps_on;
    assign lamp_test = st.lamp_test;
    assign module_status_lamp = st.status;
    assign log_valid = st.log_valid;
    assign log_code = st.log_code;
    assign log_time = st.log_time;

    // Logging is one entry per cycle; a feedback error coinciding with a discrepancy log is raised and logged a cycle later, any other second event is dropped.
    sequence s_disc_rise;
        !disc_error ##1 disc_error;
    endsequence

    a_disc_code: assert property (@(posedge clk) disable iff (!rst_b)
        s_disc_rise |-> log_valid && log_code == `DCM_ERR_DISC) // RULE_01
        else $error("discrepancy error raised without its log code");
    a_disc_hold_eq: assert property (@(posedge clk) disable iff (!rst_b)
        disc_error && !in_a && !in_b && !complementary && !bus_fault
        |=> disc_error) // RULE_02
        else $error("equivalent pair cleared from rest state");
    a_disc_hold_cp: assert property (@(posedge clk) disable iff (!rst_b)
        disc_error && complementary && !in_a && in_b |=> disc_error) // RULE_03
        else $error("complementary pair cleared from rest state");
    a_rest_no_err: assert property (@(posedge clk) disable iff (!rst_b)
        !disc_error && !complementary && !in_a && !in_b |=> !disc_error) // RULE_04
        else $error("discrepancy raised while both inputs off");
    a_pend_keep: assert property (@(posedge clk) disable iff (!rst_b)
        st.pending && !disc_error && !complementary && in_a && in_b |=> st.pending) // RULE_05
        else $error("pending discrepancy dropped by both on");
    a_fb_code: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(fb_error) |-> log_valid && log_code == `DCM_ERR_FBK) // RULE_06
        else $error("feedback error raised without its log code");
    a_uneq_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        uneq_fault && !bus_fault |=> uneq_fault) // RULE_07
        else $error("unequal data fault dropped");
    a_tog_bound: assert property (@(posedge clk) disable iff (!rst_b)
        st.tog_num <= 4'(`DCM_TOG_COUNT)) // RULE_08
        else $error("toggle count overran");
    a_bus_restart: assert property (@(posedge clk) disable iff (!rst_b)
        bus_fault |=> restart && log_code == `DCM_ERR_BUS && !disc_error) // RULE_09
        else $error("backplane fault did not restart");
    a_dip_lamps: assert property (@(posedge clk) disable iff (!rst_b)
        supply_dip && !bus_fault |=> !lamps_on ##1 !lamps_on) // RULE_10
        else $error("lamps not blanked after supply dip");
    a_status_green: assert property (@(posedge clk) disable iff (!rst_b)
        disc_error && st.lamp == DCM_LAMP_RUN |-> module_status_lamp) // RULE_11
        else $error("status lamp left green state");
    a_log_time: assert property (@(posedge clk) disable iff (!rst_b)
        log_valid |-> log_time == st.now - 32'h1) // RULE_12
        else $error("log timestamp mismatch");
endmodule

/* File: dcm_relay_model.sv */
`timescale 1ns/100ps
module dcm_relay_model
(
    input  wire logic clk,
    input  wire logic ctrl,
    input  wire logic stuck,
    output logic      sense
);
    logic [3:0] dly;
    initial sense = 1'b0;
    initial dly = 4'h0;
    // A stuck contact never follows, so the feedback monitor must time out.
    always @(posedge clk)
    begin
        if (stuck || sense == ctrl)
            dly <= 4'h0;
        else if (dly == 4'h3)
            sense <= ctrl;
        else
            dly <= dly + 4'h1;
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
`include "dcm_map.svh"
module testbench;
    import dcm_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, comp = 1'b0, in_a = 1'b0, in_b = 1'b0;
    logic        fb_ctrl = 1'b0, stuck = 1'b0, bus_fault = 1'b0, supply_dip = 1'b0;
    logic        s_in = 1'b0;
    logic [23:0] disc_time = 24'h000004, fb_max = 24'h000006;
    logic        fb_sense, disc_error, fb_error, uneq_fault, restart, lamps_on, lamp_test;
    logic        ms_lamp, log_valid;
    logic [31:0] log_code, log_time, last_code, last_time;
    int          failures = 0, cmp_count = 0;
    always #20 clk = ~clk;
    always @(posedge clk) if (log_valid === 1'b1) {last_code, last_time} <= {log_code, log_time};
    dcm_relay_model u_relay (.clk(clk), .ctrl(fb_ctrl), .stuck(stuck), .sense(fb_sense));
    dcm_monitor u_dut (.clk(clk), .rst_b(rst_b), .complementary(comp), .disc_time(disc_time),
        .in_a(in_a), .in_b(in_b), .single_in(s_in), .fb_ctrl(fb_ctrl), .fb_sense(fb_sense),
        .fb_max_delay(fb_max), .bus_fault(bus_fault), .supply_dip(supply_dip),
        .disc_error(disc_error), .fb_error(fb_error), .uneq_fault(uneq_fault),
        .restart(restart), .lamps_on(lamps_on), .lamp_test(lamp_test),
        .module_status_lamp(ms_lamp), .log_valid(log_valid), .log_code(log_code),
        .log_time(log_time));
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: pick = disc_error;
            1: pick = fb_error;
            2: pick = restart;
            3: pick = lamps_on;
            default: pick = lamp_test;
        endcase
    endfunction
    // Waits on negative edges so the registered outputs have settled.
    task automatic wait_for(input int sel, input logic lvl, input int bound);
        int n;
        n = 0;
        while (pick(sel) !== lvl)
        begin
            @(negedge clk);
            n++;
            if (n > bound)
            begin
                check("wait bound", 32'h1, 32'h0);
                print_verdict();
            end
        end
    endtask
    task automatic pair(input logic a, input logic b, input int cyc);
        in_a = a;
        in_b = b;
        repeat (cyc) @(negedge clk);
    endtask
    task automatic t_disc();
        pair(1'b1, 1'b0, 1);
        wait_for(0, 1'b1, 20);
        repeat (2) @(negedge clk);
        check("disc code", last_code, `DCM_ERR_DISC);
        check("status green", ms_lamp, 1'b1);
        pair(1'b0, 1'b0, 3);
        check("still latched", disc_error, 1'b1);
        pair(1'b1, 1'b1, 4);
        check("equiv clear", disc_error, 1'b0);
    endtask
    task automatic t_comp();
        comp = 1'b1;
        pair(1'b1, 1'b1, 1);
        wait_for(0, 1'b1, 20);
        pair(1'b1, 1'b0, 4);
        check("wrong way no clear", disc_error, 1'b1);
        pair(1'b0, 1'b1, 3);
        pair(1'b1, 1'b0, 4);
        check("comp clear", disc_error, 1'b0);
        comp = 1'b0;
        pair(1'b0, 1'b0, 4);
    endtask
    task automatic t_pending();
        pair(1'b1, 1'b0, 2);
        pair(1'b0, 1'b0, 12);
        check("cancelled", disc_error, 1'b0);
        pair(1'b1, 1'b0, 1);
        pair(1'b1, 1'b1, 12);
        check("both on keeps", disc_error, 1'b1);
        pair(1'b0, 1'b0, 3);
        pair(1'b1, 1'b1, 4);
        pair(1'b0, 1'b0, 4);
    endtask
    task automatic t_feedback();
        fb_ctrl = 1'b1;
        repeat (15) @(negedge clk);
        check("prompt relay", fb_error, 1'b0);
        stuck = 1'b1;
        fb_ctrl = 1'b0;
        wait_for(1, 1'b1, 20);
        repeat (2) @(negedge clk);
        check("fbk code", last_code, `DCM_ERR_FBK);
    endtask
    task automatic t_bus();
        logic [31:0] t0;
        t0 = last_time;
        check("uneq before restart", uneq_fault, 1'b1);
        bus_fault = 1'b1;
        @(negedge clk);
        bus_fault = 1'b0;
        wait_for(2, 1'b1, 4);
        repeat (2) @(negedge clk);
        check("bus code", last_code, `DCM_ERR_BUS);
        check("stamp advances", last_time > t0, 1'b1);
        check("fbk cleared", fb_error, 1'b0);
        check("uneq cleared", uneq_fault, 1'b0);
        stuck = 1'b0;
    endtask
    task automatic t_uneq();
        repeat (5)
        begin
            s_in = ~s_in;
            repeat (2) @(negedge clk);
        end
        check("few toggles", uneq_fault, 1'b0);
        repeat (7)
        begin
            s_in = ~s_in;
            repeat (2) @(negedge clk);
        end
        check("toggle train", uneq_fault, 1'b1);
        check("uneq code", last_code, `DCM_ERR_UNEQ);
        bus_fault = 1'b1;
        @(negedge clk);
        bus_fault = 1'b0;
        pair(1'b1, 1'b1, 3);
        pair(1'b0, 1'b0, 3);
        check("single dip", uneq_fault, 1'b0);
        pair(1'b1, 1'b1, 3);
        pair(1'b0, 1'b0, 3);
        check("second dip", uneq_fault, 1'b1);
    endtask
    task automatic t_dip();
        supply_dip = 1'b1;
        @(negedge clk);
        supply_dip = 1'b0;
        wait_for(3, 1'b0, 4);
        repeat (2) @(negedge clk);
        check("dip code", last_code, `DCM_ERR_DIP);
        wait_for(4, 1'b1, 300);
        wait_for(4, 1'b0, 1100);
        check("lamps back", lamps_on, 1'b1);
    endtask
    initial
    begin
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        check("status after reset", ms_lamp, 1'b1);
        check("no error at reset", disc_error, 1'b0);
        t_disc();
        t_comp();
        t_pending();
        t_feedback();
        t_bus();
        t_uneq();
        t_dip();
        print_verdict();
    end
endmodule
